//--- logic/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

   // register bus
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam logic [7:0] SCR_OFFSET = 8'h38;
   localparam logic [7:0] RESULT_OFFSET = 8'h39;
   localparam logic [7:0] CLKSEL_OFFSET = 8'h3A;

   // status and control fields
   localparam int DONE_BIT = 7;
   localparam int IRQ_EN_BIT = 6;
   localparam int CONT_BIT = 5;
   localparam int CHAN_LSB = 0;
   localparam int CHAN_W = 5;

   // clock select fields
   localparam int DIV_LSB = 5;
   localparam int DIV_W = 3;
   localparam int SRC_BIT = 4;

   // values after reset
   localparam logic DONE_RESET = 1'b0;
   localparam logic IRQ_EN_RESET = 1'b0;
   localparam logic CONT_RESET = 1'b0;
   localparam logic [4:0] CHAN_RESET = 5'h1F;
   localparam logic SRC_RESET = 1'b0;
   localparam logic [2:0] DIV_RESET = 3'h0;
   localparam logic [7:0] RESULT_RESET = 8'h00;

   // channel codes
   localparam logic [4:0] CH_PORTB_LAST = 5'h07;
   localparam logic [4:0] CH_PORTD_LAST = 5'h0E;
   localparam logic [4:0] CH_RESERVED = 5'h1B;
   localparam logic [4:0] CH_HIGH_REF = 5'h1D;
   localparam logic [4:0] CH_LOW_REF = 5'h1E;
   localparam logic [4:0] CH_POWER_OFF = 5'h1F;

   // conversion timing in conversion clock ticks
   localparam int SAMPLE_TICKS_DEFAULT = 8;
   localparam int CONV_TICKS = 16;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_APPROX
   } conv_state_e;

endpackage

//--- logic/conv_clk_if.sv
`timescale 1ns/1ns
interface conv_clk_if;
   logic src_bus;
   logic [2:0] divider;
   logic restart;
   logic tick;

   modport gen (
      input src_bus,
      input divider,
      input restart,
      output tick
   );

   modport ctl (
      output src_bus,
      output divider,
      output restart,
      input tick
   );
endinterface

//--- logic/conv_clock_gen.sv
`timescale 1ns/1ns
module conv_clock_gen
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // oscillator pin
   input wire logic oscillator_clock_i,
   // control side
   conv_clk_if.gen cc
);

   logic osc_s1_reg;
   logic osc_s2_reg;
   logic osc_s3_reg;
   logic osc_level_reg;
   logic [3:0] count_reg;
   logic [3:0] last;
   logic osc_rise;
   logic base_tick;
   logic tick_reg;

   // oscillator must stay well below half the bus rate
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         osc_s1_reg <= 1'b0;
         osc_s2_reg <= 1'b0;
         osc_s3_reg <= 1'b0;
      end else begin
         osc_s1_reg <= oscillator_clock_i;
         osc_s2_reg <= osc_s1_reg;
         osc_s3_reg <= osc_s2_reg;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         osc_level_reg <= 1'b0;
      end else if (osc_s2_reg == osc_s3_reg) begin
         osc_level_reg <= osc_s3_reg;
      end
   end

   assign osc_rise = (osc_s2_reg == osc_s3_reg) && osc_s3_reg &&
                     !osc_level_reg;
   assign base_tick = cc.src_bus ? 1'b1 : osc_rise;

   always_comb begin
      unique case (cc.divider)
         3'h0: last = 4'h0;
         3'h1: last = 4'h1;
         3'h2: last = 4'h3;
         3'h3: last = 4'h7;
         default: last = 4'hF;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || cc.restart) begin
         count_reg <= 4'h0;
         tick_reg <= 1'b0;
      end else if (base_tick) begin
         count_reg <= (count_reg >= last) ? 4'h0 : count_reg + 4'h1;
         tick_reg <= (count_reg >= last);
      end else begin
         tick_reg <= 1'b0;
      end
   end

   assign cc.tick = tick_reg;

endmodule // conv_clock_gen

//--- logic/adc_control_registers.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module adc_control_registers
   import adc_ctrl_pkg::*;
#(
   parameter int SAMPLE_TICKS = SAMPLE_TICKS_DEFAULT
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   // system
   input wire logic stop_mode_i,
   input wire logic oscillator_clock_i,
   // converter analog macro
   input wire logic comparator_i,
   output logic [CHAN_W-1:0] channel_select_o,
   output logic converter_power_o,
   output logic high_reference_sel_o,
   output logic low_reference_sel_o,
   output logic sample_o,
   output logic [DATA_W-1:0] trial_code_o,
   // interrupt
   output logic irq_o
);

   initial begin
      if (SAMPLE_TICKS < 1 || SAMPLE_TICKS + DATA_W != CONV_TICKS) begin
         $error("sample ticks must fill the conversion length");
      end
   end

   localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_TICKS - 1);

   conv_clk_if cc ();

   conv_clock_gen u_clock_gen (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .oscillator_clock_i(oscillator_clock_i),
      .cc(cc)
   );

   // register state
   logic done_reg;
   logic irq_en_reg;
   logic cont_reg;
   logic [CHAN_W-1:0] chan_reg;
   logic src_reg;
   logic [DIV_W-1:0] div_reg;
   logic [DATA_W-1:0] result_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic pend_reg;
   logic irq_reg;

   // conversion state
   conv_state_e state_reg;
   logic run_reg;
   logic [3:0] cnt_reg;
   logic [2:0] bit_reg;
   logic [DATA_W-1:0] sar_reg;
   logic sample_reg;

   // output side decode
   logic power_reg;
   logic high_ref_reg;
   logic low_ref_reg;

   // decoded accesses
   logic scr_wr;
   logic clk_wr;
   logic res_rd;
   logic chan_off;
   logic start_ok;
   logic complete;
   logic [DATA_W-1:0] onehot;
   logic [DATA_W-1:0] decided;
   logic [CHAN_W-1:0] chan_next;

   assign scr_wr = wr_i && (addr_i == SCR_OFFSET);
   assign clk_wr = wr_i && (addr_i == CLKSEL_OFFSET);
   assign res_rd = rd_i && (addr_i == RESULT_OFFSET);
   assign chan_off = (chan_reg == CH_POWER_OFF);
   assign start_ok = (state_reg == ST_IDLE) && run_reg && !stop_mode_i &&
                     !chan_off && !scr_wr;
   assign complete = (state_reg == ST_APPROX) && cc.tick &&
                     (bit_reg == 3'h0);
   assign onehot = DATA_W'(1) << bit_reg;
   assign decided = comparator_i ? sar_reg : (sar_reg & ~onehot);
   assign chan_next = scr_wr ? wdata_i[CHAN_LSB +: CHAN_W] : chan_reg;

   assign cc.src_bus = src_reg;
   assign cc.divider = div_reg;
   // prescaler restarts so the first tick lands within one period
   assign cc.restart = start_ok;

   // control fields
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         irq_en_reg <= IRQ_EN_RESET;
         cont_reg <= CONT_RESET;
         chan_reg <= CHAN_RESET;
      end else if (scr_wr) begin
         irq_en_reg <= wdata_i[IRQ_EN_BIT];
         cont_reg <= wdata_i[CONT_BIT];
         chan_reg <= wdata_i[CHAN_LSB +: CHAN_W];
      end
   end

   // source and prescaler; changing mid-conversion spoils the result
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         src_reg <= SRC_RESET;
         div_reg <= DIV_RESET;
      end else if (clk_wr) begin
         src_reg <= wdata_i[SRC_BIT];
         div_reg <= wdata_i[DIV_LSB +: DIV_W];
      end
   end

   // done flag: completion wins over any clear in the same cycle
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         done_reg <= DONE_RESET;
      end else if (complete && !irq_en_reg) begin
         done_reg <= 1'b1;
      end else if (scr_wr) begin
         // writable only when the new enable is set
         done_reg <= wdata_i[IRQ_EN_BIT] ? wdata_i[DONE_BIT] : 1'b0;
      end else if (res_rd && !irq_en_reg) begin
         done_reg <= 1'b0;
      end
   end

   // pending interrupt, held until a clearing access
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pend_reg <= 1'b0;
      end else if (complete && irq_en_reg) begin
         pend_reg <= 1'b1;
      end else if (scr_wr || res_rd) begin
         pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= pend_reg && irq_en_reg;
      end
   end

   // result register; no write path exists
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         result_reg <= RESULT_RESET;
      end else if (complete) begin
         // unused codes convert whatever the mux delivers
         result_reg <= decided;
      end
   end

   // read port, data in the following cycle only
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rdata_reg <= '0;
      end else if (rd_i) begin
         unique case (addr_i)
            SCR_OFFSET: rdata_reg <= {done_reg, irq_en_reg, cont_reg,
                                      chan_reg};
            RESULT_OFFSET: rdata_reg <= result_reg;
            CLKSEL_OFFSET: rdata_reg <= {div_reg, src_reg, 4'h0};
            default: rdata_reg <= '0;
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end

   // run request survives stop mode so work resumes afterwards
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         run_reg <= 1'b0;
      end else if (scr_wr) begin
         run_reg <= (wdata_i[CHAN_LSB +: CHAN_W] != CH_POWER_OFF);
      end else if (complete && !cont_reg) begin
         run_reg <= 1'b0;
      end
   end

   // conversion sequencer
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         bit_reg <= 3'h0;
         sar_reg <= '0;
         sample_reg <= 1'b0;
      end else if (scr_wr || stop_mode_i || chan_off) begin
         // a write restarts, stop aborts, power-off halts
         state_reg <= ST_IDLE;
         sample_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (start_ok) begin
                  state_reg <= ST_SAMPLE;
                  cnt_reg <= 4'h0;
                  sample_reg <= 1'b1;
               end
            end
            ST_SAMPLE: begin
               if (cc.tick) begin
                  cnt_reg <= cnt_reg + 4'h1;
                  if (cnt_reg == SAMPLE_LAST) begin
                     state_reg <= ST_APPROX;
                     sample_reg <= 1'b0;
                     bit_reg <= 3'(DATA_W - 1);
                     sar_reg <= DATA_W'(1) << (DATA_W - 1);
                  end
               end
            end
            ST_APPROX: begin
               if (cc.tick) begin
                  if (bit_reg == 3'h0) begin
                     sar_reg <= decided;
                     if (cont_reg) begin
                        state_reg <= ST_SAMPLE;
                        cnt_reg <= 4'h0;
                        sample_reg <= 1'b1;
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end else begin
                     sar_reg <= decided | (onehot >> 1);
                     bit_reg <= bit_reg - 3'h1;
                  end
               end
            end
         endcase
      end
   end

   // analog side controls
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         power_reg <= 1'b0;
         high_ref_reg <= 1'b0;
         low_ref_reg <= 1'b0;
      end else begin
         power_reg <= (chan_next != CH_POWER_OFF);
         high_ref_reg <= (chan_next == CH_HIGH_REF);
         low_ref_reg <= (chan_next == CH_LOW_REF);
      end
   end

   assign rdata_o = rdata_reg;
   assign channel_select_o = chan_reg;
   assign converter_power_o = power_reg;
   assign high_reference_sel_o = high_ref_reg;
   assign low_reference_sel_o = low_ref_reg;
   assign sample_o = sample_reg;
   assign trial_code_o = sar_reg;
   assign irq_o = irq_reg;

endmodule // adc_control_registers

//--- test/adc_control_registers_properties.sv
`timescale 1ns/1ns
module adc_control_registers_properties
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   // converter side
   input wire logic stop_mode_i,
   input wire logic [CHAN_W-1:0] channel_select_o,
   input wire logic converter_power_o,
   input wire logic high_reference_sel_o,
   input wire logic low_reference_sel_o,
   input wire logic sample_o,
   input wire logic irq_o
);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_rdata_idle_zero: assert property (
      !$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   a_power_off_code: assert property (
      channel_select_o == CH_POWER_OFF && !(wr_i && addr_i == SCR_OFFSET)
      |=> !converter_power_o)
      else $error("converter powered with all-ones channel");
   a_high_ref_sel: assert property (
      channel_select_o == CH_HIGH_REF && !(wr_i && addr_i == SCR_OFFSET)
      |=> high_reference_sel_o && !low_reference_sel_o)
      else $error("high reference not routed");
   a_low_ref_sel: assert property (
      channel_select_o == CH_LOW_REF && !(wr_i && addr_i == SCR_OFFSET)
      |=> low_reference_sel_o && !high_reference_sel_o)
      else $error("low reference not routed");
   a_read_drops_irq: assert property (
      rd_i && addr_i == RESULT_OFFSET |-> ##2 !irq_o)
      else $error("irq kept after result read");
   a_write_drops_irq: assert property (
      wr_i && addr_i == SCR_OFFSET && wdata_i[IRQ_EN_BIT] |-> ##2 !irq_o)
      else $error("irq kept after control write");
   a_irq_masked_low: assert property (
      wr_i && addr_i == SCR_OFFSET && !wdata_i[IRQ_EN_BIT]
      |-> ##2 !irq_o [*8])
      else $error("irq raised while disabled");
   a_irq_level_hold: assert property (
      $rose(irq_o) && !rd_i && !wr_i && !$past(rd_i) && !$past(wr_i)
      |=> irq_o)
      else $error("irq dropped without clearing access");
   a_stop_no_sample: assert property (
      stop_mode_i && $past(stop_mode_i) |-> !sample_o)
      else $error("sampling during stop mode");
endmodule // adc_control_registers_properties
bind adc_control_registers adc_control_registers_properties chk (
   .ref_clk_i(ref_clk_i),
   .rst_n_i(rst_n_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .stop_mode_i(stop_mode_i),
   .channel_select_o(channel_select_o),
   .converter_power_o(converter_power_o),
   .high_reference_sel_o(high_reference_sel_o),
   .low_reference_sel_o(low_reference_sel_o),
   .sample_o(sample_o),
   .irq_o(irq_o)
);

//--- test/adc_control_registers_bench.sv
`timescale 1ns/1ns
module adc_control_registers_bench;
   import adc_ctrl_pkg::*;
   logic ref_clk_i, rst_n_i, wr_i, rd_i, stop_mode_i;
   logic oscillator_clock_i, comparator_i, converter_power_o;
   logic high_reference_sel_o, low_reference_sel_o, sample_o, irq_o;
   logic [7:0] addr_i, wdata_i, rdata_o, trial_code_o, d;
   logic [4:0] channel_select_o;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   int n;
   adc_control_registers DUT (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .stop_mode_i(stop_mode_i),
      .oscillator_clock_i(oscillator_clock_i),
      .comparator_i(comparator_i),
      .channel_select_o(channel_select_o),
      .converter_power_o(converter_power_o),
      .high_reference_sel_o(high_reference_sel_o),
      .low_reference_sel_o(low_reference_sel_o),
      .sample_o(sample_o),
      .trial_code_o(trial_code_o),
      .irq_o(irq_o)
   );
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // oscillator at a quarter of the bus rate, four bus cycles a tick;
   // half rate never lets the second and third sync flops agree
   always @(posedge ref_clk_i) begin
      if (cyc % 2 == 1)
         oscillator_clock_i <= ~oscillator_clock_i;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         end_of_test;
      end
   end
   task end_of_test;
      if (err_total == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // polls done, n counts bus cycles spent
   task wait_done;
      n = 0;
      d = 8'h00;
      while (!d[7] && n < 600) begin
         rd(SCR_OFFSET);
         n = n + 2;
      end
   endtask
   task wait_irq;
      n = 0;
      while (irq_o !== 1'b1 && n < 40) begin
         @(posedge ref_clk_i);
         #1 n++;
      end
      chk({7'h00, irq_o}, 8'h01);
   endtask
   task t_reset;
      rd(SCR_OFFSET);
      chk(d, 8'h1F);
      rd(CLKSEL_OFFSET);
      chk(d, 8'h00);
      rd(8'h3B);
      chk(d, 8'h00);
      chk({7'h00, converter_power_o}, 8'h00);
      wr(RESULT_OFFSET, 8'hFF);
      rd(RESULT_OFFSET);
      chk(d, 8'h00);
   endtask
   task t_single;
      wr(CLKSEL_OFFSET, 8'h10);
      wr(SCR_OFFSET, 8'h00);
      wait_done;
      chk(d, 8'h80);
      chk(trial_code_o, 8'hFF);
      rd(RESULT_OFFSET);
      chk(d, 8'hFF);
      rd(SCR_OFFSET);
      chk(d, 8'h00);
      wr(SCR_OFFSET, 8'h00);
      wait_done;
      wr(SCR_OFFSET, 8'h01);
      rd(SCR_OFFSET);
      chk(d, 8'h01);
      wait_done;
   endtask
   task t_clock;
      logic [7:0] cv [7] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hF0, 8'h00};
      int rv [7] = '{1, 2, 4, 8, 16, 16, 4};
      for (int k = 0; k < 7; k++) begin
         wr(CLKSEL_OFFSET, cv[k]);
         rd(CLKSEL_OFFSET);
         chk(d, cv[k]);
         wr(SCR_OFFSET, 8'h00);
         wait_done;
         chk({7'h00, n >= 15 * rv[k] && n <= 18 * rv[k] + 8}, 8'h01);
         chk({7'h00, irq_o}, 8'h00);
      end
      wr(CLKSEL_OFFSET, 8'h10);
   endtask
   task t_irq;
      wr(SCR_OFFSET, 8'h40);
      wait_irq;
      repeat (5) @(posedge ref_clk_i);
      #1 chk({7'h00, irq_o}, 8'h01);
      rd(RESULT_OFFSET);
      @(posedge ref_clk_i);
      #1 chk({7'h00, irq_o}, 8'h00);
      wr(SCR_OFFSET, 8'hC0);
      rd(SCR_OFFSET);
      chk(d, 8'hC0);
      wait_irq;
      wr(SCR_OFFSET, 8'h5F);
      @(posedge ref_clk_i);
      #1 chk({7'h00, irq_o}, 8'h00);
   endtask
   task t_cont;
      wr(SCR_OFFSET, 8'h20);
      wait_done;
      rd(RESULT_OFFSET);
      chk(d, 8'hFF);
      comparator_i <= 1'b0;
      repeat (45) @(posedge ref_clk_i);
      rd(SCR_OFFSET);
      chk(d, 8'hA0);
      rd(RESULT_OFFSET);
      chk(d, 8'h00);
      wr(SCR_OFFSET, 8'h1F);
      // a completion in the write cycle would win; clear it again
      wr(SCR_OFFSET, 8'h1F);
      repeat (40) @(posedge ref_clk_i);
      rd(SCR_OFFSET);
      chk(d, 8'h1F);
      comparator_i <= 1'b1;
   endtask
   task t_chan;
      logic [4:0] cc [6] = '{5'h00, 5'h07, 5'h08, 5'h0E, 5'h1D, 5'h1E};
      for (int k = 0; k < 6; k++) begin
         wr(SCR_OFFSET, {3'h0, cc[k]});
         @(posedge ref_clk_i);
         #1 chk({3'h0, channel_select_o}, {3'h0, cc[k]});
         chk({5'h00, converter_power_o, high_reference_sel_o,
            low_reference_sel_o},
            {5'h00, 1'b1, cc[k] == 5'h1D, cc[k] == 5'h1E});
      end
      wr(SCR_OFFSET, 8'h1F);
      repeat (2) @(posedge ref_clk_i);
      #1 chk({7'h00, converter_power_o}, 8'h00);
   endtask
   task t_stop;
      wr(SCR_OFFSET, 8'h00);
      stop_mode_i <= 1'b1;
      repeat (40) @(posedge ref_clk_i);
      chk({7'h00, sample_o}, 8'h00);
      rd(SCR_OFFSET);
      chk(d, 8'h00);
      stop_mode_i <= 1'b0;
      wait_done;
      chk(d, 8'h80);
   endtask
   initial begin
      rst_n_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      stop_mode_i = 1'b0;
      oscillator_clock_i = 1'b0;
      comparator_i = 1'b1;
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      t_reset;
      t_single;
      t_clock;
      t_irq;
      t_cont;
      t_chan;
      t_stop;
      end_of_test;
   end
endmodule // adc_control_registers_bench
